/* include/chan4_dsp_consts.svh */
`ifndef CHAN4_DSP_CONSTS_SVH
`define CHAN4_DSP_CONSTS_SVH
// ****************************************
// Register offsets and reset values
// ****************************************
`define ADDR_CHAN4_VOLUME 8'h4D
`define ADDR_CHAN4_GAIN_TRIM 8'h4E
`define ADDR_CHAN4_PHASE_DELAY 8'h4F
`define ADDR_PROCESSING_CONFIG_ZERO 8'h6B
`define RST_CHAN4_VOLUME 8'hC9
`define RST_CHAN4_GAIN_TRIM 8'h80
`define RST_CHAN4_PHASE_DELAY 8'h00
`define RST_PROCESSING_CONFIG_ZERO 8'h01
// ****************************************
// Field positions
// ****************************************
`define TRIM_MSB 7
`define TRIM_LSB 4
`define DECIM_MSB 5
`define DECIM_LSB 4
`define AVG_MSB 3
`define AVG_LSB 2
`define HPF_MSB 1
`define HPF_LSB 0
`define PROC_WRITABLE_MASK 8'hFF
// ****************************************
// Gain mapping
// ****************************************
`define VOL_MUTE_CODE 8'h00
`define VOL_UNITY_CODE 8'hC9
`define TRIM_UNITY_CODE 4'h8
// Quarter-dB units per code step
`define VOL_QDB_PER_CODE 2
// 0.1 dB per trim step expressed in tenths
`define TRIM_TENTHS_PER_CODE 1
`endif

/* include/chan4_dsp_pkg.sv */
package chan4_dsp_pkg;
  typedef enum logic [1:0] {
    DECIM_LINEAR = 2'h0,
    DECIM_LOW_LAT = 2'h1,
    DECIM_ULTRA_LOW_LAT = 2'h2,
    DECIM_RESERVED = 2'h3
  } decim_type;
  typedef enum logic [1:0] {
    AVG_OFF = 2'h0,
    AVG_CH1_CH2 = 2'h1,
    AVG_RES2 = 2'h2,
    AVG_RES3 = 2'h3
  } avg_type;
  typedef enum logic [1:0] {
    HPF_CUSTOM_IIR = 2'h0,
    HPF_CUT_00025 = 2'h1,
    HPF_CUT_002 = 2'h2,
    HPF_CUT_008 = 2'h3
  } hpf_type;
endpackage

/* rtl/phase_delay_line.sv */
`timescale 1ns/100ps
// ****************************************
// Variable delay of a sample stream in modulator clock ticks
// ****************************************
module phase_delay_line #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 256
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic [7:0] delay_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] data_o
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [7:0] wptr_r;
  logic [7:0] rptr;

  assign rptr = wptr_r - delay_i;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wptr_r <= 8'h00;
    end else if (ce_i && tick_i) begin
      wptr_r <= wptr_r + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (ce_i && tick_i) begin
      mem_r[wptr_r] <= data_i;
    end
  end

  // Zero delay bypasses the memory
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      data_o <= '0;
    end else if (ce_i && tick_i) begin
      data_o <= (delay_i == 8'h00) ? data_i : mem_r[rptr];
    end
  end
endmodule

/* rtl/chan4_cal_and_dsp_config.sv */
`timescale 1ns/100ps
`include "chan4_dsp_consts.svh"
module chan4_cal_and_dsp_config #(
  parameter int SAMPLE_W = 24,
  parameter int DELAY_DEPTH = 256
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic mod_tick_i,
  input wire logic sample_valid_i,
  input wire logic signed [SAMPLE_W-1:0] ch1_sample_i,
  input wire logic signed [SAMPLE_W-1:0] ch2_sample_i,
  input wire logic signed [SAMPLE_W-1:0] ch4_sample_i,
  output logic signed [SAMPLE_W-1:0] ch4_sample_o,
  output logic signed [SAMPLE_W-1:0] sum_sample_o,
  output chan4_dsp_pkg::decim_type decimator_response_select_o,
  output chan4_dsp_pkg::avg_type channel_average_select_o,
  output chan4_dsp_pkg::hpf_type highpass_select_o
);
  import chan4_dsp_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] chan4_volume_code_r;
  logic [3:0] chan4_gain_trim_code_r;
  logic [7:0] chan4_phase_delay_code_r;
  logic [7:0] processing_config_zero_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      chan4_volume_code_r <= `RST_CHAN4_VOLUME;
    end else if (ce_i && reg_wr_i && reg_addr_i == `ADDR_CHAN4_VOLUME) begin
      chan4_volume_code_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      chan4_gain_trim_code_r <= 4'(`RST_CHAN4_GAIN_TRIM >> `TRIM_LSB);
    end else if (ce_i && reg_wr_i && reg_addr_i == `ADDR_CHAN4_GAIN_TRIM) begin
      chan4_gain_trim_code_r <= reg_wdata_i[`TRIM_MSB:`TRIM_LSB];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      chan4_phase_delay_code_r <= `RST_CHAN4_PHASE_DELAY;
    end else if (ce_i && reg_wr_i && reg_addr_i == `ADDR_CHAN4_PHASE_DELAY) begin
      chan4_phase_delay_code_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      processing_config_zero_r <= `RST_PROCESSING_CONFIG_ZERO;
    end else if (ce_i && reg_wr_i && reg_addr_i == `ADDR_PROCESSING_CONFIG_ZERO) begin
      processing_config_zero_r <= reg_wdata_i & `PROC_WRITABLE_MASK;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      unique case (reg_addr_i)
        `ADDR_CHAN4_VOLUME: reg_rdata_o <= chan4_volume_code_r;
        `ADDR_CHAN4_GAIN_TRIM: reg_rdata_o <= {chan4_gain_trim_code_r, 4'h0};
        `ADDR_CHAN4_PHASE_DELAY: reg_rdata_o <= chan4_phase_delay_code_r;
        `ADDR_PROCESSING_CONFIG_ZERO: reg_rdata_o <= processing_config_zero_r;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Shared processing selects
  // ****************************************
  // Decoded once, fanned out to every active channel
  assign decimator_response_select_o =
    decim_type'(processing_config_zero_r[`DECIM_MSB:`DECIM_LSB]);
  assign channel_average_select_o =
    avg_type'(processing_config_zero_r[`AVG_MSB:`AVG_LSB]);
  assign highpass_select_o =
    hpf_type'(processing_config_zero_r[`HPF_MSB:`HPF_LSB]);

  // ****************************************
  // Gain tables
  // ****************************************
  // Linear gain in Q2.16 for 0.5 dB steps: g = 10^(-db/20)
  // Fine steps from a base-and-offset form: code c gives (c-201)*0.5 dB
  // Coarse right shift per 6 dB plus fine table per 0.5 dB within 6 dB
  function automatic logic [17:0] fine_gain(input logic [3:0] idx);
    unique case (idx)
      4'h0: fine_gain = 18'h10000;
      4'h1: fine_gain = 18'h0F1AE;
      4'h2: fine_gain = 18'h0E429;
      4'h3: fine_gain = 18'h0D766;
      4'h4: fine_gain = 18'h0CB59;
      4'h5: fine_gain = 18'h0BFF9;
      4'h6: fine_gain = 18'h0B53C;
      4'h7: fine_gain = 18'h0AB19;
      4'h8: fine_gain = 18'h0A186;
      4'h9: fine_gain = 18'h0987D;
      4'hA: fine_gain = 18'h08FF6;
      4'hB: fine_gain = 18'h087E8;
      default: fine_gain = 18'h10000;
    endcase
  endfunction

  // Trim: 0.1 dB steps, code 8 is unity
  function automatic logic [17:0] trim_gain(input logic [3:0] code);
    unique case (code)
      4'h0: trim_gain = 18'h0E979;
      4'h1: trim_gain = 18'h0EC2E;
      4'h2: trim_gain = 18'h0EEEA;
      4'h3: trim_gain = 18'h0F1AE;
      4'h4: trim_gain = 18'h0F47A;
      4'h5: trim_gain = 18'h0F74F;
      4'h6: trim_gain = 18'h0FA2C;
      4'h7: trim_gain = 18'h0FD12;
      4'h8: trim_gain = 18'h10000;
      4'h9: trim_gain = 18'h102F7;
      4'hA: trim_gain = 18'h105F6;
      4'hB: trim_gain = 18'h108FF;
      4'hC: trim_gain = 18'h10C11;
      4'hD: trim_gain = 18'h10F2B;
      4'hE: trim_gain = 18'h1124F;
      default: trim_gain = 18'h1157C;
    endcase
  endfunction

  // ****************************************
  // Volume decomposition
  // ****************************************
  // Steps below +30 dB, six above the top code; 12 steps per halving
  logic [8:0] vol_down;
  logic [4:0] vol_shift;
  logic [3:0] vol_fine;
  logic [17:0] vol_fine_gain;
  logic [17:0] trim_mult;
  logic [35:0] total_gain_full;
  logic [17:0] total_gain;

  assign vol_down = 9'd261 - {1'b0, chan4_volume_code_r};
  assign vol_shift = 5'(vol_down / 9'd12);
  assign vol_fine = 4'(vol_down % 9'd12);
  assign vol_fine_gain = fine_gain(vol_fine);
  assign trim_mult = trim_gain(chan4_gain_trim_code_r);
  assign total_gain_full = vol_fine_gain * trim_mult;
  assign total_gain = total_gain_full[33:16];

  // ****************************************
  // Channel 4 sample path
  // ****************************************
  logic signed [SAMPLE_W-1:0] ch4_delayed;
  logic signed [SAMPLE_W+19:0] scaled_full;
  logic signed [SAMPLE_W+19:0] shifted;
  logic signed [SAMPLE_W+19:0] peak;

  phase_delay_line #(
    .WIDTH(SAMPLE_W),
    .DEPTH(DELAY_DEPTH)
  ) u_delay (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(mod_tick_i),
    .delay_i(chan4_phase_delay_code_r),
    .data_i(ch4_sample_i),
    .data_o(ch4_delayed)
  );

  // Shift of 11 leaves x32 at table unity; no left shift, so no overflow
  assign scaled_full = ch4_delayed * $signed({1'b0, total_gain});
  assign shifted = scaled_full >>> ({1'b0, vol_shift} + 6'd11);
  assign peak = {{20{1'b0}}, {1'b0, {(SAMPLE_W-1){1'b1}}}};

  // 27 dB of boost saturates at full scale rather than wrapping
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ch4_sample_o <= '0;
    end else if (ce_i && sample_valid_i) begin
      if (chan4_volume_code_r == `VOL_MUTE_CODE) begin
        ch4_sample_o <= '0;
      end else if (shifted > peak) begin
        ch4_sample_o <= peak[SAMPLE_W-1:0];
      end else if (shifted < -peak) begin
        ch4_sample_o <= {1'b1, {(SAMPLE_W-1){1'b0}}};
      end else begin
        ch4_sample_o <= shifted[SAMPLE_W-1:0];
      end
    end
  end

  // ****************************************
  // Channel summation
  // ****************************************
  logic signed [SAMPLE_W:0] pair_sum;
  assign pair_sum = ch1_sample_i + ch2_sample_i;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sum_sample_o <= '0;
    end else if (ce_i && sample_valid_i) begin
      if (channel_average_select_o == AVG_CH1_CH2) begin
        sum_sample_o <= pair_sum[SAMPLE_W:1];
      end else begin
        sum_sample_o <= ch1_sample_i;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_mute;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && sample_valid_i && chan4_volume_code_r == 8'h00) |=> ch4_sample_o == '0;
  endproperty
  a_mute: assert property (p_mute) else $error("muted sample nonzero");

  property p_trim_low_zero;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && reg_addr_i == 8'h4E) |=> reg_rdata_o[3:0] == 4'h0;
  endproperty
  a_trim_low_zero: assert property (p_trim_low_zero) else $error("trim low nibble");

  property p_vol_write;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && reg_wr_i && reg_addr_i == 8'h4D) |=> chan4_volume_code_r == $past(reg_wdata_i);
  endproperty
  a_vol_write: assert property (p_vol_write) else $error("volume write lost");

  property p_unity_gain;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (chan4_volume_code_r == 8'hC9 && chan4_gain_trim_code_r == 4'h8) |-> total_gain == 18'h10000;
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("unity gain wrong");

  property p_avg;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && sample_valid_i && processing_config_zero_r[3:2] == 2'h1)
        |=> (SAMPLE_W+1)'(sum_sample_o)
          == (SAMPLE_W+1)'($past(ch1_sample_i) + $past(ch2_sample_i)) >>> 1;
  endproperty
  a_avg: assert property (p_avg) else $error("average wrong");

  property p_hpf_follow;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && reg_wr_i && reg_addr_i == 8'h6B) |=> highpass_select_o == hpf_type'($past(reg_wdata_i[1:0]));
  endproperty
  a_hpf_follow: assert property (p_hpf_follow) else $error("highpass select");

  property p_decim_follow;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && reg_wr_i && reg_addr_i == 8'h6B)
        |=> decimator_response_select_o == decim_type'($past(reg_wdata_i[5:4]));
  endproperty
  a_decim_follow: assert property (p_decim_follow) else $error("decimator select");

  property p_reset_vals;
    @(posedge sys_clk_i)
      $rose(rst_n_i) |-> chan4_volume_code_r == 8'hC9 && chan4_gain_trim_code_r == 4'h8
        && processing_config_zero_r == 8'h01 && chan4_phase_delay_code_r == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values");

  property p_nodelay;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && mod_tick_i && chan4_phase_delay_code_r == 8'h00) |=> ch4_delayed == $past(ch4_sample_i);
  endproperty
  a_nodelay: assert property (p_nodelay) else $error("zero delay not bypass");
endmodule

/* verification/testbench.sv */
`timescale 1ns/100ps
`include "chan4_dsp_consts.svh"
module testbench;
  import chan4_dsp_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;
  logic clk, rst_n, ce, wr, tick, sv;
  logic [7:0] addr, wdata, rdata, rv;
  logic signed [23:0] ch1, ch2, ch4, ch4_out, sum_out;
  decim_type decim;
  avg_type avg;
  hpf_type hpf;
  int error_cnt = 0;
  int checked = 0;
  row_type rows[8];
  logic [7:0] codes[3] = '{8'h00, 8'h03, 8'hFF};
  chan4_cal_and_dsp_config #(.SAMPLE_W(24), .DELAY_DEPTH(256)) chan4_cal_and_dsp_config_i (
    .sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .mod_tick_i(tick), .sample_valid_i(sv),
    .ch1_sample_i(ch1), .ch2_sample_i(ch2), .ch4_sample_i(ch4), .ch4_sample_o(ch4_out),
    .sum_sample_o(sum_out), .decimator_response_select_o(decim),
    .channel_average_select_o(avg), .highpass_select_o(hpf));
  // ****************************************
  // Bus, sample and check tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 v = rdata;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask
  task automatic smp();
    @(posedge clk);
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (10000) @(posedge clk);
    error_cnt++;
    results();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    tick = 1'b0;
    sv = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ch1 = 24'sh0;
    ch2 = 24'sh0;
    ch4 = 24'sh0;
    rows = '{'{8'h4D, 8'hFF, 8'hFF}, '{8'h4D, 8'h00, 8'h00}, '{8'h4E, 8'hF0, 8'hF0},
      '{8'h4E, 8'h70, 8'h70}, '{8'h4F, 8'hFF, 8'hFF}, '{8'h6B, 8'h00, 8'h00},
      '{8'h6B, 8'h27, 8'h27}, '{8'h50, 8'hFF, 8'h00}};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h4D, rv);
    chk(24'(rv), 24'hC9);
    rd_reg(8'h4E, rv);
    chk(24'(rv), 24'h80);
    rd_reg(8'h4F, rv);
    chk(24'(rv), 24'h00);
    rd_reg(8'h6B, rv);
    chk(24'(rv), 24'h01);
    chk(24'(decim), 24'h0);
    chk(24'(avg), 24'h0);
    chk(24'(hpf), 24'h1);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, rv);
      chk(24'(rv), 24'(rows[i].e));
    end
    for (int d = 0; d < 3; d++) begin
      for (int s = 0; s < 2; s++) begin
        for (int h = 0; h < 4; h++) begin
          wr_reg(8'h6B, {2'b00, 2'(d), 2'(s), 2'(h)});
          #1;
          chk(24'(decim), 24'(d));
          chk(24'(avg), 24'(s));
          chk(24'(hpf), 24'(h));
        end
      end
    end
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h4D, rv);
    chk(24'(rv), 24'hC9);
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'h4F, 8'h55);
    ce <= 1'b1;
    rd_reg(8'h4F, rv);
    chk(24'(rv), 24'h00);
    wr_reg(8'h6B, 8'h04);
    ch1 <= -24'sd4;
    ch2 <= 24'sd2;
    ch4 <= 24'sh012345;
    ticks(2);
    smp();
    chk(sum_out, 24'hFFFFFF);
    chk(ch4_out, 24'h012345);
    wr_reg(8'h6B, 8'h00);
    smp();
    chk(sum_out, 24'hFFFFFC);
    wr_reg(8'h4D, 8'h00);
    smp();
    chk(ch4_out, 24'h000000);
    wr_reg(8'h4D, 8'hFF);
    ch4 <= 24'sh7FFFFF;
    ticks(1);
    smp();
    chk(ch4_out, 24'h7FFFFF);
    @(posedge clk);
    ch4 <= 24'sh800000;
    ticks(1);
    smp();
    chk(ch4_out, 24'h800000);
    wr_reg(8'h4D, 8'hBD);
    ch4 <= 24'sh100000;
    ticks(1);
    smp();
    chk(24'(ch4_out > 24'sh07F000 && ch4_out < 24'sh081800), 24'h1);
    wr_reg(8'h4D, 8'hC9);
    wr_reg(8'h4E, 8'h00);
    smp();
    chk(24'(ch4_out > 24'sh0E8000 && ch4_out < 24'sh0EB000), 24'h1);
    wr_reg(8'h4E, 8'hF0);
    smp();
    chk(24'(ch4_out > 24'sh114000 && ch4_out < 24'sh117000), 24'h1);
    wr_reg(8'h4E, 8'h80);
    // Old value must survive exactly code ticks after the input changes
    foreach (codes[i]) begin
      wr_reg(8'h4F, codes[i]);
      ch4 <= 24'sh000111;
      ticks(260);
      ch4 <= 24'sh000222;
      ticks(int'(codes[i]));
      smp();
      chk(ch4_out, 24'h000111);
      ticks(1);
      smp();
      chk(ch4_out, 24'h000222);
    end
    results();
  end
endmodule
